/* dual_port_burst_sram_pkg.sv */
// Constants, register map and carrier types of the dual-port burst RAM
package dual_port_burst_sram_pkg;

    // ========================================================
    // Array geometry: 15 address bits for 32K words, 14 for 16K
    localparam int ADDR_W = 15;
    localparam int DATA_W = 36;
    localparam int WORDS = 1 << ADDR_W;
    localparam int PORTS = 2;
    localparam int CAP_PORT = 1;

    // ========================================================
    // Capture FIFO
    localparam int FIFO_W = DATA_W;
    localparam int FIFO_DEPTH = 8;
    localparam int FIFO_CNT_W = 4;
    localparam logic [FIFO_CNT_W-1:0] FIFO_SLACK = 4'h2;

    // ========================================================
    // APB register map (byte addresses)
    localparam int APB_AW = 12;
    localparam logic [APB_AW-1:0] CTRL_OFS = 12'h000;
    localparam logic [APB_AW-1:0] STATUS_OFS = 12'h004;
    localparam logic [APB_AW-1:0] COUNT_A_OFS = 12'h008;
    localparam logic [APB_AW-1:0] COUNT_B_OFS = 12'h00c;
    localparam logic [2:0] CTRL_RESET = 3'h0;
    localparam int CTRL_CAPTURE_BIT = 0;
    localparam int CTRL_SLEEP_A_BIT = 1;
    localparam int CTRL_SLEEP_B_BIT = 2;
    localparam int STATUS_FIFO_LSB = 4;

    // ========================================================
    // Pins of one port, sampled on the clock edge
    typedef struct packed {
        logic selectN;
        logic writeN;
        logic outEnableN;
        logic addressLoadStrobeN;
        logic countAdvanceEnableN;
        logic counterClearN;
        logic counterReadbackN;
        logic latencySelect;
        logic [ADDR_W-1:0] address;
        logic [DATA_W-1:0] writeData;
    } port_pins_type;

    typedef struct packed {
        logic valid;
        logic drive;
        logic [DATA_W-1:0] data;
    } read_stage_type;

endpackage

/* dual_port_burst_sram.sv */
// Dual-port burst RAM with APB control and a read-capture FIFO
//
// Register access over APB and the register addresses were left to the implementer.
`timescale 1ns/100ps

// ============================================================
// Capture FIFO
module capture_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 8,
    parameter int CNT_W = 4
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic inValid,
    output logic inReady,
    input wire logic [WIDTH-1:0] inData,
    output logic outValid,
    input wire logic outReady,
    output logic [WIDTH-1:0] outData,
    output logic [CNT_W-1:0] level
);
    localparam int PTR_W = $clog2(DEPTH);
    localparam logic [CNT_W-1:0] FULL_LEVEL = CNT_W'(DEPTH);

    logic [WIDTH-1:0] store [DEPTH];
    logic [PTR_W-1:0] wrPtr_r;
    logic [PTR_W-1:0] rdPtr_r;
    logic [CNT_W-1:0] count_r;
    logic push;
    logic pop;

    assign inReady = (count_r != FULL_LEVEL);
    assign outValid = (count_r != '0);
    assign push = inValid & inReady;
    assign pop = outValid & outReady;
    assign outData = store[rdPtr_r];
    assign level = count_r;

    always_ff @(posedge ref_clk)
    begin
        if (push)
        begin
            store[wrPtr_r] <= inData;
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wrPtr_r <= '0;
            rdPtr_r <= '0;
            count_r <= '0;
        end
        else
        begin
            if (push)
            begin
                wrPtr_r <= PTR_W'(wrPtr_r + 1'b1);
            end
            if (pop)
            begin
                rdPtr_r <= PTR_W'(rdPtr_r + 1'b1);
            end
            if (push && !pop)
            begin
                count_r <= CNT_W'(count_r + 1'b1);
            end
            else if (pop && !push)
            begin
                count_r <= CNT_W'(count_r - 1'b1);
            end
        end
    end
endmodule // capture_fifo

// ============================================================
// Dual-port array
module dual_port_burst_sram (
    input wire logic ref_clk,
    input wire logic rst,
    input wire dual_port_burst_sram_pkg::port_pins_type portIn [2],
    output logic [35:0] dataOut [2],
    output logic dataOeN [2],
    output logic portReady [2],
    output logic capValid,
    input wire logic capReady,
    output logic [35:0] capData,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr
);
    localparam int AW = dual_port_burst_sram_pkg::ADDR_W;
    localparam int DW = dual_port_burst_sram_pkg::DATA_W;

    logic [DW-1:0] mem [dual_port_burst_sram_pkg::WORDS];
    dual_port_burst_sram_pkg::port_pins_type pins_r [2];
    logic [AW-1:0] count_r [2];
    logic [AW-1:0] effAddr [2];
    logic active [2];
    logic doWrite [2];
    dual_port_burst_sram_pkg::read_stage_type flow_r [2];
    dual_port_burst_sram_pkg::read_stage_type pipe_r [2];
    logic accept [2];
    logic sleep [2];
    logic [2:0] ctrl_r;
    logic [31:0] prdata_r;
    logic [3:0] fifoLevel;
    logic fifoInReady;
    logic capPush;

    // ========================================================
    // Per-port capture, counter and read path
    for (genvar p = 0; p < 2; p++)
    begin : gPort
        assign sleep[p] = ctrl_r[dual_port_burst_sram_pkg::CTRL_SLEEP_A_BIT
            + p];
        assign active[p] = !pins_r[p].selectN;
        assign doWrite[p] = active[p] && !pins_r[p].writeN;

        // Clear wins, then external address, then advance
        always_comb
        begin
            if (!pins_r[p].counterClearN)
            begin
                effAddr[p] = '0;
            end
            else if (!pins_r[p].addressLoadStrobeN)
            begin
                effAddr[p] = pins_r[p].address;
            end
            else if (!pins_r[p].countAdvanceEnableN)
            begin
                effAddr[p] = AW'(count_r[p] + 1'b1);
            end
            else
            begin
                effAddr[p] = count_r[p];
            end
        end

        // Inputs taken on the edge; a refused or sleeping cycle is idle
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                pins_r[p] <= '{selectN: 1'b1, writeN: 1'b1,
                    outEnableN: 1'b1, addressLoadStrobeN: 1'b1,
                    countAdvanceEnableN: 1'b1, counterClearN: 1'b1,
                    counterReadbackN: 1'b1, default: '0};
            end
            else
            begin
                pins_r[p] <= portIn[p];
                if (!accept[p] || sleep[p])
                begin
                    pins_r[p].selectN <= 1'b1;
                end
            end
        end

        // Load only with both strobe and advance low
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                count_r[p] <= '0;
            end
            else if (!pins_r[p].counterClearN)
            begin
                count_r[p] <= '0;
            end
            else if (active[p] && !pins_r[p].countAdvanceEnableN)
            begin
                count_r[p] <= effAddr[p];
            end
        end

        // Flow-through stage, read at the captured address
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                flow_r[p] <= '0;
            end
            else
            begin
                flow_r[p].valid <= active[p] && pins_r[p].writeN;
                flow_r[p].drive <= active[p] && pins_r[p].writeN
                    && !pins_r[p].outEnableN;
                if (active[p] && !pins_r[p].counterReadbackN)
                begin
                    flow_r[p].data <= DW'(effAddr[p]);
                end
                else if (active[p])
                begin
                    flow_r[p].data <= mem[effAddr[p]];
                end
            end
        end

        // Output register adds one cycle in pipelined mode
        always_ff @(posedge ref_clk or posedge rst)
        begin
            if (rst)
            begin
                pipe_r[p] <= '0;
            end
            else
            begin
                pipe_r[p] <= flow_r[p];
            end
        end

        always_comb
        begin
            if (pins_r[p].latencySelect)
            begin
                dataOut[p] = pipe_r[p].data;
                dataOeN[p] = !pipe_r[p].drive;
            end
            else
            begin
                dataOut[p] = flow_r[p].data;
                dataOeN[p] = !flow_r[p].drive;
            end
        end

        assign portReady[p] = accept[p];
    end

    // Writes of both ports; the second port lands last on a clash
    always_ff @(posedge ref_clk)
    begin
        for (int p = 0; p < 2; p++)
        begin
            if (doWrite[p])
            begin
                mem[effAddr[p]] <= pins_r[p].writeData;
            end
        end
    end

    // ========================================================
    // Capture of the second port's read words
    localparam int CP = dual_port_burst_sram_pkg::CAP_PORT;

    // Room is kept for the two words already in the flow-through read path
    assign accept[0] = 1'b1;
    assign accept[1] = !ctrl_r[dual_port_burst_sram_pkg::CTRL_CAPTURE_BIT]
        || (fifoLevel < 4'(dual_port_burst_sram_pkg::FIFO_DEPTH)
            - dual_port_burst_sram_pkg::FIFO_SLACK);
    assign capPush = ctrl_r[dual_port_burst_sram_pkg::CTRL_CAPTURE_BIT]
        && (pins_r[CP].latencySelect ? pipe_r[CP].valid
            : flow_r[CP].valid);

    capture_fifo #(
        .WIDTH(dual_port_burst_sram_pkg::FIFO_W),
        .DEPTH(dual_port_burst_sram_pkg::FIFO_DEPTH),
        .CNT_W(dual_port_burst_sram_pkg::FIFO_CNT_W)
    ) uFifo (
        .ref_clk(ref_clk),
        .rst(rst),
        .inValid(capPush),
        .inReady(fifoInReady),
        .inData(dataOut[CP]),
        .outValid(capValid),
        .outReady(capReady),
        .outData(capData),
        .level(fifoLevel)
    );

    // ========================================================
    // APB slave, no wait states
    logic setup;
    logic mapped;

    assign setup = psel && !penable;
    assign pready = 1'b1;
    assign mapped = (paddr == dual_port_burst_sram_pkg::CTRL_OFS)
        || (paddr == dual_port_burst_sram_pkg::STATUS_OFS)
        || (paddr == dual_port_burst_sram_pkg::COUNT_A_OFS)
        || (paddr == dual_port_burst_sram_pkg::COUNT_B_OFS);
    assign pslverr = psel && penable && !mapped;
    assign prdata = prdata_r;

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            ctrl_r <= dual_port_burst_sram_pkg::CTRL_RESET;
        end
        else if (psel && penable && pwrite
            && paddr == dual_port_burst_sram_pkg::CTRL_OFS)
        begin
            ctrl_r <= pwdata[2:0];
        end
    end

    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            prdata_r <= '0;
        end
        else if (setup && !pwrite)
        begin
            case (paddr)
                dual_port_burst_sram_pkg::CTRL_OFS:
                    prdata_r <= {29'h0, ctrl_r};
                dual_port_burst_sram_pkg::STATUS_OFS:
                    prdata_r <= {24'h0, fifoLevel, 1'b0, fifoInReady,
                        !active[1], !active[0]};
                dual_port_burst_sram_pkg::COUNT_A_OFS:
                    prdata_r <= 32'(count_r[0]);
                dual_port_burst_sram_pkg::COUNT_B_OFS:
                    prdata_r <= 32'(count_r[1]);
                default:
                    prdata_r <= '0;
            endcase
        end
    end
endmodule // dual_port_burst_sram

/* dual_port_burst_sram_checker.sv */
// Port A timing, capture stream and APB slave-error checks for the burst RAM
`timescale 1ns/100ps
module dual_port_burst_sram_checker (
    input wire logic ref_clk,
    input wire logic rst,
    input wire dual_port_burst_sram_pkg::port_pins_type portIn [2],
    input wire logic [35:0] dataOut [2],
    input wire logic dataOeN [2],
    input wire logic capValid,
    input wire logic capReady,
    input wire logic [35:0] capData,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pslverr
);
    // ========================================================
    // Decoded port A request
    wire logic idle = portIn[0].selectN;
    wire logic lat = portIn[0].latencySelect;
    wire logic rd = !idle && portIn[0].writeN && !portIn[0].outEnableN;
    wire logic rb = rd && !lat && !portIn[0].counterReadbackN;
    wire logic [2:0] cc = {portIn[0].addressLoadStrobeN,
        portIn[0].countAdvanceEnableN, portIn[0].counterClearN};
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_flow_drive: assert property (
        rd && !lat ##1 !lat |-> ##1 !dataOeN[0]) else $error("flow idle");
    a_pipe_drive: assert property (
        rd && lat ##1 lat ##1 lat |-> ##1 !dataOeN[0]) else $error("pipe idle");
    a_pipe_late: assert property (
        rd && lat && $past(idle) ##1 lat |-> ##1 dataOeN[0])
        else $error("pipe read too early");
    a_power_down: assert property (
        idle && $past(idle) |-> ##2 dataOeN[0]) else $error("idle port drove");
    a_write_quiet: assert property (
        !idle && !portIn[0].writeN && $past(idle) ##1 idle |-> ##1 dataOeN[0])
        else $error("write drove bus");
    a_clear_zero: assert property (
        rb && !portIn[0].counterClearN ##1 !lat |-> ##1 dataOut[0] == 36'h0)
        else $error("clear not zero");
    a_load_addr: assert property (
        rb && cc == 3'b001 ##1 !lat
        |-> ##1 dataOut[0] == {21'h0, $past(portIn[0].address, 2)})
        else $error("load address wrong");
    // An advance without strobe reads back one past the previous address
    a_burst_step: assert property (
        rb && cc != 3'b011 ##1 (rb && cc == 3'b101) ##1 !lat
        |-> ##1 dataOut[0][14:0] == $past(dataOut[0][14:0]) + 15'h1)
        else $error("count step wrong");
    a_cap_hold: assert property (
        capValid && !capReady |=> capValid && $stable(capData))
        else $error("capture word dropped");
    a_unmapped_err: assert property (
        psel && penable && paddr > 12'h00c |-> pslverr)
        else $error("no slave error");
endmodule // dual_port_burst_sram_checker

bind dual_port_burst_sram dual_port_burst_sram_checker i_chk (.ref_clk,
    .rst, .portIn, .dataOut, .dataOeN, .capValid, .capReady, .capData,
    .paddr, .psel, .penable, .pslverr);

/* host_port_model.sv */
// Host model that bursts words through port B of the burst RAM
`timescale 1ns/100ps
module host_port_model (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic en,
    input wire logic doWrite,
    input wire logic portReady,
    output dual_port_burst_sram_pkg::port_pins_type pins
);
    logic [14:0] cnt_r;
    // ========================================================
    // Burst sequencer: word k goes to address k
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            cnt_r <= 15'h0;
            pins <= '1;
        end
        else if (!pins.selectN && !portReady)
            pins <= pins;
        else if (en)
        begin
            // First word loads address zero, later words advance
            pins <= {1'b0, !doWrite, 1'b0, cnt_r != 15'h0, 4'b0110, 15'h0,
                21'h0, cnt_r};
            cnt_r <= cnt_r + 15'h1;
        end
        else
        begin
            pins.selectN <= 1'b1;
            pins.address <= ~pins.address;
            pins.writeData <= ~pins.writeData;
            cnt_r <= 15'h0;
        end
    end
endmodule // host_port_model

/* dual_port_burst_sram_tb_top.sv */
// Self-checking bench for the dual-port burst RAM
`timescale 1ns/100ps
module dual_port_burst_sram_tb_top;
    typedef dual_port_burst_sram_pkg::port_pins_type pins_type;
    logic ref_clk = 1'b0, rst = 1'b1, capReady = 1'b0, en = 1'b0;
    logic doWrite = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic capValid, pslverr, pready, e, l;
    logic dataOeN [2], portReady [2];
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, r;
    logic [35:0] dataOut [2];
    logic [35:0] capData, d, gotA [$], capQ [$], gotB [$];
    logic [14:0] a;
    pins_type pinsA = '1, p;
    wire pins_type portIn [2];
    integer seed = 32'he80c, failures = 0, num_checks = 0;
    assign portIn[0] = pinsA;
    dual_port_burst_sram i_dut (.ref_clk, .rst, .portIn, .dataOut, .dataOeN,
        .portReady, .capValid, .capReady, .capData, .paddr, .psel, .penable,
        .pwrite, .pwdata, .prdata, .pready, .pslverr);
    host_port_model i_host (.ref_clk, .rst, .en, .doWrite,
        .portReady(portReady[1]), .pins(portIn[1]));
    initial forever #2 ref_clk = ~ref_clk;
    // ========================================================
    // Monitors, drivers and checks
    always @(posedge ref_clk)
    begin
        if (dataOeN[0] === 1'b0) gotA.push_back(dataOut[0]);
        if (dataOeN[1] === 1'b0) gotB.push_back(dataOut[1]);
        if (capValid === 1'b1 && capReady === 1'b1) capQ.push_back(capData);
    end
    task automatic cmp(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            failures++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk(input logic [35:0] exp);
        cmp(gotA.size() ? gotA.pop_front() : 36'hx, exp);
    endtask
    function automatic pins_type req(input logic wr, input logic lt,
        input logic [14:0] ad, input logic [35:0] dt, input logic [3:0] k);
        return {1'b0, !wr, 1'b0, k, lt, ad, dt};
    endfunction
    task automatic op(input pins_type q);
        @(posedge ref_clk) pinsA <= q;
        @(posedge ref_clk)
        begin
            pinsA.selectN <= 1'b1;
            pinsA.writeData <= ~q.writeData;
        end
        repeat (3) @(posedge ref_clk);
        #1;
    endtask
    task automatic apb(input logic w, input logic [11:0] ad,
        input logic [31:0] wd);
        @(posedge ref_clk)
        begin
            psel <= 1'b1;
            paddr <= ad;
            pwrite <= w;
            pwdata <= wd;
        end
        @(posedge ref_clk) penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic final_report;
        $display("checks=%0d failures=%0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial
    begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        final_report();
    end
    initial
    begin
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        repeat (12)
        begin
            a = 15'($random(seed));
            d = 36'({$random(seed), $random(seed)});
            l = 1'($random(seed));
            op(req(1'b1, l, a, d, 4'b0111));
            op(req(1'b0, 1'b0, a, 36'h0, 4'b0111));
            chk(d);
            op(req(1'b0, 1'b1, a, 36'h0, 4'b0111));
            chk(d);
        end
        p = req(1'b0, 1'b1, a, 36'h0, 4'b0111);
        p.selectN = 1'b1;
        op(p);
        cmp(36'(gotA.size()), 36'h0);
        for (int m = 0; m < 2; m++)
        begin
            @(posedge ref_clk) pinsA <= req(1'b0, m[0], 15'h7ffe, d, 4'b0010);
            @(posedge ref_clk) pinsA <= req(1'b0, m[0], a, d, 4'b1010);
            op(req(1'b0, m[0], a, d, 4'b1010));
            chk(36'h7ffe);
            chk(36'h7fff);
            chk(36'h0);
        end
        op(req(1'b0, 1'b0, 15'h1234, 36'h0, 4'b0000));
        chk(36'h0);
        apb(1'b0, dual_port_burst_sram_pkg::COUNT_A_OFS, 32'h0);
        cmp({4'h0, r}, 36'h0);
        apb(1'b0, 12'h010, 32'h0);
        cmp({35'h0, e}, 36'h1);
        // Port B forced asleep: its requests must be dropped
        apb(1'b1, dual_port_burst_sram_pkg::CTRL_OFS, 32'h4);
        apb(1'b0, dual_port_burst_sram_pkg::CTRL_OFS, 32'h0);
        cmp({4'h0, r}, 36'h4);
        en <= 1'b1;
        repeat (4) @(posedge ref_clk);
        apb(1'b0, dual_port_burst_sram_pkg::STATUS_OFS, 32'h0);
        cmp({35'h0, r[1]}, 36'h1);
        en <= 1'b0;
        apb(1'b1, dual_port_burst_sram_pkg::CTRL_OFS, 32'h0);
        en <= 1'b1;
        doWrite <= 1'b1;
        repeat (8) @(posedge ref_clk);
        apb(1'b0, dual_port_burst_sram_pkg::STATUS_OFS, 32'h0);
        cmp({35'h0, r[1]}, 36'h0);
        repeat (19) @(posedge ref_clk);
        en <= 1'b0;
        apb(1'b1, dual_port_burst_sram_pkg::CTRL_OFS, 32'h1);
        doWrite <= 1'b0;
        en <= 1'b1;
        for (int i = 0; i < 200 && portReady[1] !== 1'b0; i++)
            @(posedge ref_clk);
        repeat (8) @(posedge ref_clk);
        apb(1'b0, dual_port_burst_sram_pkg::STATUS_OFS, 32'h0);
        cmp(36'(r[7:4] >= 4'h6), 36'h1);
        en <= 1'b0;
        repeat (40) @(posedge ref_clk) capReady <= 1'($random(seed));
        repeat (10) @(posedge ref_clk) capReady <= 1'b1;
        cmp(36'(capQ.size() >= 6), 36'h1);
        foreach (capQ[i]) cmp(capQ[i], 36'(i));
        apb(1'b0, dual_port_burst_sram_pkg::STATUS_OFS, 32'h0);
        cmp({32'h0, r[7:4]}, 36'h0);
        cmp(36'(gotB.size() == capQ.size()), 36'h1);
        foreach (gotB[i]) cmp(gotB[i], 36'(i));
        apb(1'b0, dual_port_burst_sram_pkg::COUNT_B_OFS, 32'h0);
        cmp({4'h0, r}, 36'(gotB.size() - 1));
        final_report();
    end
endmodule // dual_port_burst_sram_tb_top
